//--- hw/cap_pkg.sv
package cap_pkg;
  // parity latency field encodings
  localparam logic [2:0] LAT_OFF = 3'h0;
  localparam logic [2:0] LAT_4 = 3'h1;
  localparam logic [2:0] LAT_5 = 3'h2;
  localparam logic [2:0] LAT_6 = 3'h3;
  localparam logic [2:0] LAT_8 = 3'h4;
  localparam logic [3:0] LAT_CYC_4 = 4'h4;
  localparam logic [3:0] LAT_CYC_5 = 4'h5;
  localparam logic [3:0] LAT_CYC_6 = 4'h6;
  localparam logic [3:0] LAT_CYC_8 = 4'h8;
  localparam int DLY_DEPTH = 8;
  // timing figures, in ns, with derived cycle counts at 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int ALERT_ON_NS = 500;
  localparam int ALERT_PW_MIN_NS = 3200;
  localparam int RAS_MIN_NS = 1600;
  localparam int ALERT_ON_CYC = ALERT_ON_NS / CLK_PERIOD_NS;
  localparam int ALERT_PW_CYC = (ALERT_PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAS_MIN_CYC = (RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ALERT_PW_CNT = 8'(ALERT_PW_CYC);
  localparam logic [7:0] RAS_MIN_CNT = 8'(RAS_MIN_CYC);
  localparam logic [7:0] ALERT_ON_CNT = 8'(ALERT_ON_CYC);
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;

  // one command/address frame as it arrives on the bus
  typedef struct packed {
    logic act;
    logic ras;
    logic cas;
    logic we;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [13:0] addr;
    logic a17;
    logic [2:0] cid;
    logic par;
  } cap_frame_t;

  // captured error log, four 8-bit locations
  typedef struct packed {
    logic [7:0] loc3;
    logic [7:0] loc2;
    logic [7:0] loc1;
    logic [7:0] loc0;
  } cap_log_t;

  typedef enum logic [2:0] {
    CAP_IDLE = 3'b000,
    CAP_ALERT = 3'b001,
    CAP_DRAIN = 3'b010,
    CAP_PRECH = 3'b011,
    CAP_HOLD = 3'b100
  } cap_state_t;
endpackage : cap_pkg

//--- hw/cap_delay_line.sv
`timescale 1ns/1ps
// command delay line; output from a register tap unless depth is zero, length chosen per cycle
module cap_delay_line (
  // clock and reset
  input wire logic clock,
  input wire logic rst_sync_n,
  // frame in
  input wire logic in_valid,
  input wire cap_pkg::cap_frame_t in_frame,
  input wire logic [3:0] depth,
  // frame out
  output logic out_valid,
  output cap_pkg::cap_frame_t out_frame
);
  logic [cap_pkg::DLY_DEPTH-1:0] vld_r;
  cap_pkg::cap_frame_t frm_r [cap_pkg::DLY_DEPTH];
  wire [2:0] tap = 3'(depth - 4'h1);

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      vld_r <= '0;
    end else begin
      vld_r <= {vld_r[cap_pkg::DLY_DEPTH-2:0], in_valid};
    end
  end

  always_ff @(posedge clock) begin
    frm_r[0] <= in_frame;
    for (int i = 1; i < cap_pkg::DLY_DEPTH; i++) begin
      frm_r[i] <= frm_r[i-1];
    end
  end

  // a depth of zero bypasses the line entirely
  assign out_valid = (depth == 4'h0) ? in_valid : vld_r[tap];
  assign out_frame = (depth == 4'h0) ? in_frame : frm_r[tap];
endmodule : cap_delay_line

//--- hw/cap_parity_checker.sv
`timescale 1ns/1ps
module cap_parity_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // command bus from controller
  input wire logic cs_n,
  input wire cap_pkg::cap_frame_t frame,
  // mode register write
  input wire logic mode_wr,
  input wire logic [2:0] mode_latency,
  input wire logic mode_status,
  input wire logic mode_persist,
  input wire logic stacked_part,
  // core side
  input wire logic refresh_busy,
  input wire logic [4:0] base_read_lat,
  input wire logic [4:0] base_write_lat,
  output logic cmd_valid,
  output cap_pkg::cap_frame_t cmd_frame,
  output logic precharge_all,
  output logic cancel_pending,
  output logic [4:0] read_lat,
  output logic [4:0] write_lat,
  // status
  output logic alert_n,
  output logic parity_enabled,
  output logic error_status,
  output cap_pkg::cap_log_t error_log
);
  logic rst_m_r;
  logic rst_s_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  function automatic logic [3:0] lat_cycles(input logic [2:0] code);
    case (code)
      cap_pkg::LAT_4: lat_cycles = cap_pkg::LAT_CYC_4;
      cap_pkg::LAT_5: lat_cycles = cap_pkg::LAT_CYC_5;
      cap_pkg::LAT_6: lat_cycles = cap_pkg::LAT_CYC_6;
      cap_pkg::LAT_8: lat_cycles = cap_pkg::LAT_CYC_8;
      default: lat_cycles = 4'h0;
    endcase
  endfunction : lat_cycles

  logic [2:0] latency_r;
  logic status_r;
  logic persist_r;
  logic alert_n_r;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic [7:0] pw_r;
  cap_pkg::cap_state_t state_r;
  cap_pkg::cap_state_t state_nxt;
  cap_pkg::cap_log_t log_r;
  logic logged_r;

  wire enabled = (latency_r != cap_pkg::LAT_OFF);
  wire [3:0] lat_cyc = lat_cycles(latency_r);
  wire busy = (state_r != cap_pkg::CAP_IDLE);
  // checking pauses after an error until status cleared, or alert ends in persistent mode
  wire check_on = enabled && !busy && (!status_r || persist_r);
  wire selected = !cs_n;
  // stacking id pins count as zero on a monolithic part
  wire [2:0] cid_eff = stacked_part ? frame.cid : 3'h0;
  wire [21:0] covered = {frame.act, frame.ras, frame.cas, frame.we, frame.bg,
                         frame.ba, frame.addr};
  wire par_bad = ^{covered, frame.a17 & stacked_part, cid_eff, frame.par};
  wire err_evt = selected && check_on && par_bad;
  // no new command is accepted during the alert window; hold is still inside the pulse
  wire accept = selected && !err_evt && !busy;

  // latency written by mode write; status only accepts a zero
  wire status_clr = mode_wr && !mode_status;

  always_ff @(posedge clock or negedge rst_s_r) begin
    if (!rst_s_r) begin
      latency_r <= cap_pkg::LAT_OFF;
      persist_r <= 1'b0;
      status_r <= 1'b0;
    end else begin
      if (mode_wr) begin
        latency_r <= mode_latency;
        persist_r <= mode_persist;
      end
      // a new error wins over a same-cycle clear
      if (err_evt) begin
        status_r <= 1'b1;
      end else if (status_clr) begin
        status_r <= 1'b0;
      end
    end
  end

  // first error frame kept until status cleared
  always_ff @(posedge clock or negedge rst_s_r) begin
    if (!rst_s_r) begin
      log_r <= '0;
      logged_r <= 1'b0;
    end else if (err_evt && !logged_r) begin
      log_r.loc0 <= frame.addr[7:0];
      log_r.loc1 <= {frame.cas, frame.we, frame.addr[13:8]};
      log_r.loc2 <= {frame.par, frame.act, frame.bg, frame.ba, frame.a17, frame.ras};
      log_r.loc3 <= {1'b0, 1'b1, latency_r, cid_eff};
      logged_r <= 1'b1;
    end else if (status_clr && !err_evt) begin
      logged_r <= 1'b0;
      log_r.loc3[6] <= 1'b0;
    end
  end

  // error sequence: alert, drain, precharge all, hold out pulse width
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r == cap_pkg::CNT_ZERO) ? cnt_r : 8'(cnt_r - cap_pkg::CNT_ONE);
    case (state_r)
      cap_pkg::CAP_IDLE: begin
        if (err_evt) begin
          state_nxt = cap_pkg::CAP_ALERT;
          cnt_nxt = cap_pkg::RAS_MIN_CNT;
        end
      end
      cap_pkg::CAP_ALERT: begin
        state_nxt = cap_pkg::CAP_DRAIN;
      end
      cap_pkg::CAP_DRAIN: begin
        // wait out row minimum active time counted from the error, and any busy refresh
        if (cnt_r == cap_pkg::CNT_ZERO && !refresh_busy) begin
          state_nxt = cap_pkg::CAP_PRECH;
        end
      end
      cap_pkg::CAP_PRECH: begin
        state_nxt = cap_pkg::CAP_HOLD;
      end
      cap_pkg::CAP_HOLD: begin
        if (pw_r == cap_pkg::CNT_ZERO && !refresh_busy) begin
          state_nxt = cap_pkg::CAP_IDLE;
        end
      end
      default: state_nxt = cap_pkg::CAP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_s_r) begin
    if (!rst_s_r) begin
      state_r <= cap_pkg::CAP_IDLE;
      cnt_r <= cap_pkg::CNT_ZERO;
      pw_r <= cap_pkg::CNT_ZERO;
      alert_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (err_evt && !busy) begin
        pw_r <= cap_pkg::ALERT_PW_CNT;
      end else if (pw_r != cap_pkg::CNT_ZERO) begin
        pw_r <= 8'(pw_r - cap_pkg::CNT_ONE);
      end
      // alert falls the cycle after the bad frame, well inside the alert-on time
      if (err_evt && !busy) begin
        alert_n_r <= 1'b0;
      end else if (state_nxt == cap_pkg::CAP_IDLE) begin
        alert_n_r <= 1'b1;
      end
    end
  end

  // every accepted command is delayed by the parity latency
  logic dly_valid;
  cap_pkg::cap_frame_t dly_frame;
  cap_delay_line u_dly (
    .clock(clock),
    .rst_sync_n(rst_s_r),
    .in_valid(accept),
    .in_frame(frame),
    .depth(lat_cyc),
    .out_valid(dly_valid),
    .out_frame(dly_frame)
  );

  logic cmd_valid_r;
  cap_pkg::cap_frame_t cmd_frame_r;
  always_ff @(posedge clock or negedge rst_s_r) begin
    if (!rst_s_r) begin
      cmd_valid_r <= 1'b0;
      cmd_frame_r <= '0;
    end else begin
      // queued commands already in the line still drain
      cmd_valid_r <= dly_valid;
      cmd_frame_r <= dly_frame;
    end
  end

  // pending reads in the uncertain window are cancelled so no strobes go out
  assign cancel_pending = err_evt && !busy;
  assign precharge_all = (state_r == cap_pkg::CAP_PRECH);
  assign read_lat = 5'(base_read_lat + 5'(lat_cyc));
  assign write_lat = 5'(base_write_lat + 5'(lat_cyc));
  assign cmd_valid = cmd_valid_r;
  assign cmd_frame = cmd_frame_r;
  assign alert_n = alert_n_r;
  assign parity_enabled = enabled;
  assign error_status = status_r;
  assign error_log = log_r;
endmodule : cap_parity_checker

//--- testbench/cap_props.sv
`timescale 1ns/1ps
module cap_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // inputs
  input wire logic cs_n,
  input wire cap_pkg::cap_frame_t frame,
  input wire logic mode_wr,
  input wire logic [2:0] mode_latency,
  input wire logic mode_status,
  input wire logic stacked_part,
  input wire logic [4:0] base_read_lat,
  input wire logic [4:0] base_write_lat,
  // outputs
  input wire logic precharge_all,
  input wire logic cancel_pending,
  input wire logic [4:0] read_lat,
  input wire logic [4:0] write_lat,
  input wire logic alert_n,
  input wire logic parity_enabled,
  input wire logic error_status,
  input wire cap_pkg::cap_log_t error_log
);
  localparam int PW = cap_pkg::ALERT_PW_CYC;
  wire odd = ^{frame.act, frame.ras, frame.cas, frame.we, frame.bg, frame.ba, frame.addr,
    frame.a17 & stacked_part, frame.cid & {3{stacked_part}}, frame.par};
  // alert high stands in for the idle state, which is not visible here
  wire chk_on = parity_enabled && !error_status && alert_n;
  logic [2:0] lat_r;
  logic [7:0] low_r;
  logic seen_r;
  wire [4:0] lat_c = (lat_r == 3'h1) ? 5'h04 : (lat_r == 3'h2) ? 5'h05 :
    (lat_r == 3'h3) ? 5'h06 : (lat_r == 3'h4) ? 5'h08 : 5'h00;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lat_r <= 3'h0;
      low_r <= 8'h00;
      seen_r <= 1'b0;
    end else begin
      if (mode_wr) lat_r <= mode_latency;
      low_r <= alert_n ? 8'h00 : low_r + 8'h01;
      seen_r <= alert_n ? 1'b0 : (seen_r | precharge_all);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_bad;
    !cs_n && chk_on && odd;
  endsequence
  sequence s_release;
    $rose(alert_n);
  endsequence
  a_bad_alert: assert property (s_bad |=> !alert_n) else $error("alert missing");
  a_bad_status: assert property (s_bad |=> error_status) else $error("status not set");
  a_bad_cancel: assert property (s_bad |-> cancel_pending) else $error("no cancel");
  a_pulse_width: assert property (s_release |-> low_r >= PW) else $error("pulse short");
  a_prech_first: assert property (s_release |-> seen_r) else $error("no precharge");
  a_latency_enable: assert property (mode_wr |=> parity_enabled == ($past(mode_latency) != 3'h0))
    else $error("enable wrong");
  a_read_lat: assert property (read_lat == base_read_lat + lat_c) else $error("read lat");
  a_write_lat: assert property (write_lat == base_write_lat + lat_c) else $error("wr lat");
  a_log_kept: assert property (error_status && !mode_wr |=> $stable(error_log))
    else $error("log changed");
  a_no_set_wr: assert property (mode_wr && mode_status && !error_status && cs_n
    |=> !error_status) else $error("status set by write");
endmodule : cap_props
bind cap_parity_checker cap_props u_props (.clock(clock), .rst_n(rst_n), .cs_n(cs_n),
  .frame(frame), .mode_wr(mode_wr), .mode_latency(mode_latency), .mode_status(mode_status),
  .stacked_part(stacked_part), .base_read_lat(base_read_lat), .base_write_lat(base_write_lat),
  .precharge_all(precharge_all), .cancel_pending(cancel_pending), .read_lat(read_lat),
  .write_lat(write_lat), .alert_n(alert_n), .parity_enabled(parity_enabled),
  .error_status(error_status), .error_log(error_log));

//--- testbench/cap_ctrl_model.sv
`timescale 1ns/1ps
module cap_ctrl_model (
  // clock
  input wire logic clock,
  // request from bench
  input wire logic req,
  input wire logic bad,
  input wire logic stacked,
  input wire cap_pkg::cap_frame_t cmd,
  // command bus
  output logic cs_n,
  output cap_pkg::cap_frame_t frame
);
  cap_pkg::cap_frame_t good;
  cap_pkg::cap_frame_t idle_r = '0;
  always_comb begin
    good = cmd;
    good.par = bad ^ (^{cmd.act, cmd.ras, cmd.cas, cmd.we, cmd.bg, cmd.ba, cmd.addr,
      cmd.a17 & stacked, cmd.cid & {3{stacked}}});
  end
  // deselected bus shows the inverse of the last frame, never a held value
  assign cs_n = !req;
  assign frame = req ? good : idle_r;
  always @(posedge clock) if (req) idle_r <= ~good;
endmodule : cap_ctrl_model

//--- testbench/test_ca_parity_checker.sv
`timescale 1ns/1ps
module test_ca_parity_checker;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0, bad = 1'b0, stk = 1'b0, pseen = 1'b0, rb = 1'b0;
  logic mode_wr = 1'b0, mode_status = 1'b0, mode_persist = 1'b0;
  logic [2:0] mode_latency = 3'h0;
  logic cs_n, cmd_valid, precharge_all, cancel_pending, alert_n, parity_enabled, error_status;
  logic [4:0] read_lat, write_lat;
  logic [13:0] fa;
  cap_pkg::cap_frame_t cmd = '0, frame, cmd_frame;
  cap_pkg::cap_log_t error_log;
  int fails = 0, num_checks = 0, jv, ja;
  always #25 clock = ~clock;
  // cleared by each new request so every error sequence shows its own precharge
  always @(posedge clock) begin
    if (precharge_all === 1'b1) begin
      pseen <= 1'b1;
    end else if (req) begin
      pseen <= 1'b0;
    end
  end
  cap_ctrl_model u_ctrl (.clock(clock), .req(req), .bad(bad), .stacked(stk), .cmd(cmd),
    .cs_n(cs_n), .frame(frame));
  cap_parity_checker DUT (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .frame(frame),
    .mode_wr(mode_wr), .mode_latency(mode_latency), .mode_status(mode_status),
    .mode_persist(mode_persist), .stacked_part(stk), .refresh_busy(rb),
    .base_read_lat(5'h0B), .base_write_lat(5'h09), .cmd_valid(cmd_valid),
    .cmd_frame(cmd_frame), .precharge_all(precharge_all), .cancel_pending(cancel_pending),
    .read_lat(read_lat), .write_lat(write_lat), .alert_n(alert_n),
    .parity_enabled(parity_enabled), .error_status(error_status), .error_log(error_log));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic mwr(input logic [2:0] l, input logic s, input logic p);
    mode_latency = l;
    mode_status = s;
    mode_persist = p;
    mode_wr = 1'b1;
    @(negedge clock);
    mode_wr = 1'b0;
    @(negedge clock);
  endtask : mwr
  // fixed 20-cycle watch: longest latency plus margin
  task automatic send(input logic [13:0] a, input logic b);
    cmd.addr = a;
    bad = b;
    req = 1'b1;
    @(negedge clock);
    req = 1'b0;
    jv = -1;
    ja = -1;
    for (int k = 0; k < 20; k++) begin
      if (cmd_valid === 1'b1 && jv < 0) begin
        jv = k;
        fa = cmd_frame.addr;
      end
      if (alert_n === 1'b0 && ja < 0) ja = k;
      @(negedge clock);
    end
  endtask : send
  task automatic wrel;
    int n;
    n = 0;
    while (alert_n !== 1'b1 && n < 200) begin
      n++;
      @(negedge clock);
    end
    if (n == 200) begin
      fails++;
      complete_run();
    end
    chk(pseen, 1'b1);
  endtask : wrel
  task automatic t_reset;
    chk(parity_enabled, 1'b0);
    chk(alert_n, 1'b1);
    mwr(3'h0, 1'b1, 1'b0);
    chk(error_status, 1'b0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_latency;
    int j0;
    logic [3:0] cyc [4] = '{4'h4, 4'h5, 4'h6, 4'h8};
    cmd.a17 = 1'b1;
    cmd.act = 1'b1;
    cmd.cid = 3'h5;
    send(14'h0155, 1'b0);
    j0 = jv;
    for (int i = 0; i < 4; i++) begin
      stk = i[0];
      mwr(3'(i + 1), 1'b0, 1'b0);
      chk(read_lat, 5'h0B + cyc[i]);
      chk(write_lat, 5'h09 + cyc[i]);
      send(14'h2AAA - 14'(i), 1'b0);
      chk(jv - j0, cyc[i]);
      chk(fa, 14'h2AAA - 14'(i));
      mwr(3'h0, 1'b0, 1'b0);
    end
    $display("latency test done");
  endtask : t_latency
  task automatic t_error;
    stk = 1'b1;
    mwr(3'h1, 1'b0, 1'b0);
    send(14'h1234, 1'b1);
    chk(jv, -1);
    chk(ja >= 0 && ja <= cap_pkg::ALERT_ON_CYC, 1);
    chk(error_status, 1'b1);
    chk(error_log.loc0, 8'h34);
    chk(error_log.loc1, 8'h12);
    chk(error_log.loc2, 8'h42);
    chk(error_log.loc3, 8'h4D);
    wrel();
    send(14'h0777, 1'b1);
    chk(ja, -1);
    chk(jv >= 0, 1);
    chk(error_log.loc0, 8'h34);
    mwr(3'h1, 1'b1, 1'b0);
    chk(error_status, 1'b1);
    mwr(3'h1, 1'b0, 1'b0);
    chk(error_status, 1'b0);
    send(14'h0777, 1'b1);
    chk(ja >= 0, 1);
    // a busy refresh holds the drain, so alert must outlast its usual release
    rb = 1'b1;
    repeat (60) @(negedge clock);
    chk(alert_n, 1'b0);
    rb = 1'b0;
    wrel();
    $display("error test done");
  endtask : t_error
  task automatic t_persist;
    mwr(3'h1, 1'b0, 1'b1);
    send(14'h0042, 1'b1);
    wrel();
    send(14'h0043, 1'b1);
    chk(ja >= 0, 1);
    chk(error_status, 1'b1);
    wrel();
    mwr(3'h0, 1'b0, 1'b0);
    $display("persist test done");
  endtask : t_persist
  initial begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_reset();
    t_latency();
    t_error();
    t_persist();
    complete_run();
  end
endmodule : test_ca_parity_checker
